// file: rtl/fram_pkg.sv
// Purpose: Shared constants and types for the two-wire serial byte-memory slave.
// Assumes: One system clock at 250 MHz samples every bus pin.
// Notes:   The slave logic's named constants live here once; widths and bit slices such as [12:8] stay inline.
package fram_pkg;

  // ************************************************************
  // Array geometry
  // ************************************************************
  localparam int          MEM_ADDR_W    = 13;            // Address latch width, 8192 locations.
  localparam int          MEM_DATA_W    = 8;             // One byte per location.
  localparam logic [12:0] MEM_ADDR_ZERO = 13'h0000;      // Address latch value after reset.
  localparam logic [12:0] MEM_ADDR_STEP = 13'h0001;      // Auto-increment step; wraps at the top.

  // ************************************************************
  // Slave address byte layout
  // ************************************************************
  localparam logic [3:0]  DEV_TYPE_CODE = 4'ha;          // Device-type code in bits 7 to 4.
  localparam int          DEV_TYPE_MSB  = 7;             // Top bit of the device-type field.
  localparam int          DEV_TYPE_LSB  = 4;             // Bottom bit of the device-type field.
  localparam int          DEV_SEL_MSB   = 3;             // Top bit of the select field.
  localparam int          DEV_SEL_LSB   = 1;             // Bottom bit of the select field.
  localparam int          DEV_RW_BIT    = 0;             // Direction bit, one means read.
  localparam int          ADDR_HI_MSB   = 4;             // Top bit of the high address byte that is kept; bits 4 to 0 are kept.

  // ************************************************************
  // Bit counting and clocking
  // ************************************************************
  localparam logic [3:0]  BIT_CNT_ZERO  = 4'h0;          // Bit counter value at the start of a byte.
  localparam logic [3:0]  BIT_CNT_ONE   = 4'h1;          // Bit counter step.
  localparam logic [3:0]  BIT_CNT_FULL  = 4'h8;          // Eight bits make a byte.
  localparam int          SYNC_STAGES   = 2;             // Flip-flops ahead of any pin logic.
  localparam logic [5:0]  PIN_RESET_VAL = 6'h03;         // Reset levels: SCL and SDA high, straps and protect low.
  localparam int          CLK_PERIOD_NS = 4;             // System clock period.
  localparam int          SCL_MIN_PER_NS = 1000;         // Fastest bus clock, 1 MHz.
  localparam int          SCL_MIN_PER_CYC = SCL_MIN_PER_NS / CLK_PERIOD_NS; // Cycles per fastest bus bit.

  // ************************************************************
  // Which byte of a transaction is being received
  // ************************************************************
  typedef enum logic [1:0]
  {
    BYTE_DEV  = 2'h0,                                    // Slave address byte.
    BYTE_AHI  = 2'h1,                                    // High memory address byte.
    BYTE_ALO  = 2'h2,                                    // Low memory address byte.
    BYTE_DATA = 2'h3                                     // Data byte to store.
  } byte_kind_t;

  // ************************************************************
  // Bus sequencer states, Gray coded along the usual path
  // ************************************************************
  typedef enum logic [2:0]
  {
    ST_IDLE    = 3'b000,                                 // Not addressed; waits for a start.
    ST_RX_BYTE = 3'b001,                                 // Shifting a byte in from the master.
    ST_TX_ACK  = 3'b011,                                 // Pulling the line low for an acknowledge.
    ST_TX_BYTE = 3'b010,                                 // Shifting a read byte out.
    ST_RX_ACK  = 3'b110                                  // Sampling the master's acknowledge.
  } bus_state_t;

endpackage

// file: rtl/pin_sync.sv
// Purpose: Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes: Inputs are slow levels relative to clk.
// Notes:   The first stage feeds only the second stage.
module pin_sync #(
  parameter int               WIDTH     = 1,             // Number of pins carried.
  parameter logic [WIDTH-1:0] RESET_VAL = '0             // Idle level of each pin, taken in reset.
) (
  input  wire logic             clk,                     // System clock.
  input  wire logic             rst_n,                   // Asynchronous reset, active low.
  input  wire logic [WIDTH-1:0] pin_in,                  // Raw pin levels.
  output logic      [WIDTH-1:0] pin_sync_out             // Levels safe for clocked logic.
);

  logic [WIDTH-1:0] meta_reg;                            // First stage, read only by the second.
  logic [WIDTH-1:0] stable_reg;                          // Second stage.

  // ************************************************************
  // Two flip-flops per pin
  // ************************************************************
  // Resets to each pin's idle level, so edge detectors see no false edge after reset.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg   <= RESET_VAL;
      stable_reg <= RESET_VAL;
    end
    else
    begin
      meta_reg   <= pin_in;
      stable_reg <= meta_reg;
    end
  end

  assign pin_sync_out = stable_reg;

endmodule

// file: rtl/serial_fram_i2c_slave.sv
// Purpose: Slave logic of an 8192-byte nonvolatile memory on a two-wire serial bus.
// Assumes: clk at 250 MHz oversamples SCL and SDA; the master owns SCL.
// Notes:   The bus is open drain; the wire level is resolved outside this module.
module serial_fram_i2c_slave
  import fram_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = fram_pkg::DEV_TYPE_CODE // Device-type code expected in the address byte.
) (
  input  wire logic       clk,                           // System clock, 250 MHz.
  input  wire logic       rst_n,                         // Asynchronous reset, active low.
  input  wire logic       scl_in,                        // Serial clock pin level.
  input  wire logic       sda_in,                        // Serial data wire level.
  output logic            sda_out,                       // Serial data drive value, always low.
  output logic            sda_oe,                        // High while the slave pulls the data line low.
  input  wire logic [2:0] device_select_straps,          // Select strap pins.
  input  wire logic       write_protect                  // Whole-array write protect pin.
);

  import fram_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [MEM_DATA_W-1:0] mem_array [0:(1<<MEM_ADDR_W)-1]; // Byte array.
  logic [5:0]            pins_sync;                      // Synchronised pin levels.
  logic                  scl_s;                          // Synchronised SCL.
  logic                  sda_s;                          // Synchronised SDA.
  logic [2:0]            strap_s;                        // Synchronised select straps.
  logic                  wp_s;                           // Synchronised write protect.
  logic                  scl_prev_reg;                   // SCL one cycle earlier.
  logic                  sda_prev_reg;                   // SDA one cycle earlier.
  bus_state_t            state_reg;                      // Bus sequencer state.
  bus_state_t            state_next;                     // Next sequencer state.
  byte_kind_t            kind_reg;                       // Which byte is being received.
  byte_kind_t            kind_next;                      // Next byte kind.
  logic [3:0]            bit_cnt_reg;                    // Rising edges seen in this byte.
  logic [3:0]            bit_cnt_next;                   // Next bit count.
  logic [7:0]            rx_shift_reg;                   // Incoming byte.
  logic [7:0]            rx_shift_next;                  // Next incoming byte.
  logic [7:0]            tx_shift_reg;                   // Outgoing byte, MSB in bit 7.
  logic [7:0]            tx_shift_next;                  // Next outgoing byte.
  logic [12:0]           addr_reg;                       // Current address latch.
  logic [12:0]           addr_next;                      // Next address latch.
  logic                  read_reg;                       // Transaction direction, one is read.
  logic                  read_next;                      // Next direction.
  logic                  acked_reg;                      // Master acknowledged the last read byte.
  logic                  acked_next;                     // Next acknowledge flag.
  logic                  oe_reg;                         // Data line pull-down enable.
  logic                  oe_next;                        // Next pull-down enable.
  logic                  sda_out_reg;                    // Drive value, held low.

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Every pin passes two flip-flops; a full SCL bit at 1 MHz spans many samples.
  pin_sync #(
    .WIDTH        (6),
    .RESET_VAL    (PIN_RESET_VAL)
  ) u_pin_sync (
    .clk          (clk),
    .rst_n        (rst_n),
    .pin_in       ({write_protect, device_select_straps, sda_in, scl_in}),
    .pin_sync_out (pins_sync)
  );

  assign scl_s   = pins_sync[0];
  assign sda_s   = pins_sync[1];
  assign strap_s = pins_sync[4:2];                       // An open strap resolves low.
  assign wp_s    = pins_sync[5];                         // An open protect pin resolves low.

  // ************************************************************
  // Bus event decode
  // ************************************************************
  wire scl_rise   = scl_s & ~scl_prev_reg;               // Sample point for incoming bits.
  wire scl_fall   = ~scl_s & scl_prev_reg;               // Change point for outgoing bits.
  wire start_cond = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s; // SDA falls while SCL high.
  wire stop_cond  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s; // SDA rises while SCL high.
  wire byte_done  = (bit_cnt_reg == BIT_CNT_FULL);       // Eight bits have been clocked.
  wire [7:0] rx_shifted = {rx_shift_reg[6:0], sda_s};    // Incoming byte with this bit added.

  // Address byte decode.
  wire type_ok  = (rx_shift_reg[DEV_TYPE_MSB:DEV_TYPE_LSB] == DEV_TYPE);
  wire sel_ok   = (rx_shift_reg[DEV_SEL_MSB:DEV_SEL_LSB] == strap_s);
  wire dev_hit  = type_ok & sel_ok;
  wire dir_read = rx_shift_reg[DEV_RW_BIT];

  // Array read port and incremented address.
  wire [7:0]  mem_rd   = mem_array[addr_reg];            // Byte at the current address.
  wire [12:0] addr_inc = addr_reg + MEM_ADDR_STEP;       // Rolls from the top to zero.

  // Array write strobe: a whole data byte has been taken; protect blocks it.
  wire mem_we = (state_reg == ST_RX_BYTE) & scl_fall & byte_done & (kind_reg == BYTE_DATA) & ~wp_s;

  // ************************************************************
  // Sequencer next-state logic
  // ************************************************************
  // Start and stop override every state; otherwise work happens on SCL edges.
  always_comb
  begin
    state_next    = state_reg;
    kind_next     = kind_reg;
    bit_cnt_next  = bit_cnt_reg;
    rx_shift_next = rx_shift_reg;
    tx_shift_next = tx_shift_reg;
    addr_next     = addr_reg;
    read_next     = read_reg;
    acked_next    = acked_reg;
    oe_next       = oe_reg;
    if (start_cond)
    begin
      // A start aborts anything and expects a slave address next.
      state_next   = ST_RX_BYTE;
      kind_next    = BYTE_DEV;
      bit_cnt_next = BIT_CNT_ZERO;
      oe_next      = 1'b0;
    end
    else if (stop_cond)
    begin
      // A stop ends the transaction; the address latch is kept.
      state_next = ST_IDLE;
      oe_next    = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          oe_next = 1'b0;
        end
        ST_RX_BYTE:
        begin
          if (scl_rise && !byte_done)
          begin
            // Incoming bits are taken MSB first on the rising edge.
            rx_shift_next = rx_shifted;
            bit_cnt_next  = bit_cnt_reg + BIT_CNT_ONE;
          end
          else if (scl_fall && byte_done)
          begin
            // Byte complete: decide whether to acknowledge it.
            state_next = ST_TX_ACK;
            oe_next    = 1'b1;
            unique case (kind_reg)
              BYTE_DEV:
              begin
                read_next = dir_read;
                if (!dev_hit)
                begin
                  state_next = ST_IDLE;                  // Not selected: stay silent.
                  oe_next    = 1'b0;
                end
              end
              BYTE_AHI:
              begin
                addr_next[12:8] = rx_shift_reg[ADDR_HI_MSB:0]; // Upper three bits ignored.
              end
              BYTE_ALO:
              begin
                addr_next[7:0] = rx_shift_reg;
              end
              BYTE_DATA:
              begin
                addr_next = addr_inc;                    // Advances even when protected.
              end
            endcase
          end
        end
        ST_TX_ACK:
        begin
          if (scl_fall)
          begin
            // End of the acknowledge clock; next byte begins.
            bit_cnt_next = BIT_CNT_ZERO;
            if (read_reg && kind_reg == BYTE_DEV)
            begin
              // Read: drive the first bit straight after the falling edge.
              state_next    = ST_TX_BYTE;
              tx_shift_next = mem_rd;
              oe_next       = ~mem_rd[7];
            end
            else
            begin
              state_next = ST_RX_BYTE;
              oe_next    = 1'b0;
              if (kind_reg != BYTE_DATA)
              begin
                kind_next = byte_kind_t'(kind_reg + 2'h1);
              end
            end
          end
        end
        ST_TX_BYTE:
        begin
          if (scl_rise)
          begin
            bit_cnt_next = bit_cnt_reg + BIT_CNT_ONE;
          end
          else if (scl_fall)
          begin
            if (byte_done)
            begin
              // Release the line for the master's acknowledge; step the address first.
              state_next = ST_RX_ACK;
              oe_next    = 1'b0;
              addr_next  = addr_inc;
            end
            else
            begin
              // Next bit, MSB first, changes only after a falling edge.
              tx_shift_next = {tx_shift_reg[6:0], 1'b0};
              oe_next       = ~tx_shift_reg[6];
            end
          end
        end
        ST_RX_ACK:
        begin
          if (scl_rise)
          begin
            acked_next = ~sda_s;                         // Low means acknowledge.
          end
          else if (scl_fall)
          begin
            bit_cnt_next = BIT_CNT_ZERO;
            if (acked_reg)
            begin
              // Acknowledged: send the next sequential byte.
              state_next    = ST_TX_BYTE;
              tx_shift_next = mem_rd;
              oe_next       = ~mem_rd[7];
            end
            else
            begin
              state_next = ST_IDLE;                      // Missing acknowledge ends the read.
              oe_next    = 1'b0;
            end
          end
        end
        default:
        begin
          state_next = ST_IDLE;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // Sequencer registers
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg    <= ST_IDLE;
      kind_reg     <= BYTE_DEV;
      bit_cnt_reg  <= BIT_CNT_ZERO;
      rx_shift_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      addr_reg     <= MEM_ADDR_ZERO;
      read_reg     <= 1'b0;
      acked_reg    <= 1'b0;
      oe_reg       <= 1'b0;
      sda_out_reg  <= 1'b0;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      state_reg    <= state_next;
      kind_reg     <= kind_next;
      bit_cnt_reg  <= bit_cnt_next;
      rx_shift_reg <= rx_shift_next;
      tx_shift_reg <= tx_shift_next;
      addr_reg     <= addr_next;
      read_reg     <= read_next;
      acked_reg    <= acked_next;
      oe_reg       <= oe_next;
      sda_out_reg  <= 1'b0;                              // Open drain never drives high.
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  // ************************************************************
  // Byte array write port
  // ************************************************************
  // The byte lands in the array on the edge that ends it, before the acknowledge.
  always_ff @(posedge clk)
  begin
    if (mem_we)
    begin
      mem_array[addr_reg] <= rx_shift_reg;
    end
  end

  assign sda_out = sda_out_reg;
  assign sda_oe  = oe_reg;

endmodule

// file: tb/fram_slave_properties.sv
// Purpose: Bus-level properties of the serial byte-memory slave.
// Assumes: Pins are sampled raw on clk, two cycles ahead of the slave's synchronised copies.
// Notes:   Helper logic follows the bit count of every frame.
module fram_slave_properties
  import fram_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = fram_pkg::DEV_TYPE_CODE // Device-type code the slave answers to.
) (
  input wire logic       clk,                  // System clock.
  input wire logic       rst_n,                // Asynchronous reset, active low.
  input wire logic       scl_in,               // Serial clock level.
  input wire logic       sda_in,               // Resolved data wire level.
  input wire logic       sda_out,              // Slave drive value.
  input wire logic       sda_oe,               // Slave pulls the wire low while high.
  input wire logic [2:0] device_select_straps, // Strap levels.
  input wire logic       write_protect         // Write-protect level.
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Frame tracking
  // ************************************************************
  logic       scl_q;  // SCL one sample ago.
  logic       sda_q;  // SDA one sample ago.
  logic [3:0] cnt;    // Rises seen in the current byte cell.
  logic [7:0] sr;     // Bits shifted in from the wire.
  logic       first;  // The current byte is the slave address.
  logic       sel;    // The slave was addressed in this frame.
  logic       rd;     // The frame is a read.
  wire logic  rise     = scl_in & ~scl_q;
  wire logic  fall     = ~scl_in & scl_q;
  wire logic  start    = scl_in & scl_q & sda_q & ~sda_in;
  wire logic  stop     = scl_in & scl_q & ~sda_q & sda_in;
  wire logic  match    = (sr[7:4] == DEV_TYPE) && (sr[3:1] == device_select_straps);
  wire logic  byte_end = fall && (cnt == 4'h8);

  // Counts bits per cell and records the address decision, as a reference for the slave.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt   <= 4'h0;
      sr    <= 8'h00;
      first <= 1'b0;
      sel   <= 1'b0;
      rd    <= 1'b0;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (start || stop)
      begin
        cnt   <= 4'h0;
        first <= start;
        sel   <= 1'b0;
      end
      else if (rise)
      begin
        cnt   <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        sr    <= (cnt == 4'h8) ? sr : {sr[6:0], sda_in};
        first <= first && (cnt != 4'h8);
      end
      else if (byte_end && first)
      begin
        sel <= match;
        rd  <= sr[0];
      end
    end
  end

  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_drive_low_only: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("slave drove the data wire high");
  chk_release_idle: assert property ($rose(rst_n) |-> !sda_oe)
    else $error("slave pulls the wire right after reset");
  chk_drive_after_fall: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in) && !$past(scl_in, 2))
    else $error("slave changed its output outside the clock low phase");
  chk_addr_ack: assert property (byte_end && first && match |-> ##[2:5] sda_oe)
    else $error("matching address byte not acknowledged");
  chk_addr_nak: assert property (byte_end && first && !match |-> !sda_oe [*8])
    else $error("foreign address byte acknowledged");
  chk_write_ack: assert property (byte_end && sel && !rd |-> ##[2:5] sda_oe)
    else $error("written byte not acknowledged");
  chk_nak_release: assert property (rise && cnt == 4'h8 && sel && rd && sda_in |-> !sda_oe [*8])
    else $error("slave kept driving after the master refused a byte");
  chk_stop_release: assert property (stop |-> ##[1:5] !sda_oe)
    else $error("slave held the wire after a stop");

  cov_write_ack: cover property (byte_end && sel && !rd ##[2:5] sda_oe);
  cov_addr_nak: cover property (byte_end && first && !match);
  cov_read_nak: cover property (rise && cnt == 4'h8 && sel && rd && sda_in);
endmodule

bind serial_fram_i2c_slave fram_slave_properties #(.DEV_TYPE(DEV_TYPE)) u_props (
  .clk                  (clk),
  .rst_n                (rst_n),
  .scl_in               (scl_in),
  .sda_in               (sda_in),
  .sda_out              (sda_out),
  .sda_oe               (sda_oe),
  .device_select_straps (device_select_straps),
  .write_protect        (write_protect)
);

// file: tb/bus_master_model.sv
// Purpose: Behavioural two-wire bus master that owns SCL.
// Assumes: Both lines have a pull-up; the bench resolves the data wire.
// Notes:   SCL stands high between frames; a bit cell is 48 ns, or 192 ns when slow.
module bus_master_model (
  input  wire logic clk,      // Bench clock that paces every phase.
  input  wire logic slow,     // High stretches each phase fourfold.
  input  wire logic sda_wire, // Resolved data wire.
  output logic      scl,      // Serial clock drive.
  output logic      sda_drv   // Data drive; high releases the wire.
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus: both lines released.
  initial
  begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // One third of a cell, so the clock never runs faster than 48 ns per bit.
  task automatic phase();
    repeat (slow ? 16 : 4) @(posedge clk);
  endtask

  // Start from idle, or a repeated start when SCL is low.
  // The first phase lets a pending SCL update settle before it is tested.
  task automatic bus_start();
    phase();
    if (!scl)
    begin
      sda_drv <= 1'b1;
      phase();
      scl <= 1'b1;
      phase();
    end
    sda_drv <= 1'b0;
    phase();
    scl <= 1'b0;
  endtask

  // Stop, leaving both lines released.
  task automatic bus_stop();
    phase();
    sda_drv <= 1'b0;
    phase();
    scl <= 1'b1;
    phase();
    sda_drv <= 1'b1;
    phase();
  endtask

  // Data set mid-low so it is stable around both clock edges; wire sampled at the rise.
  task automatic bit_cell(input logic v, output logic s);
    phase();
    sda_drv <= v;
    phase();
    scl <= 1'b1;
    s = sda_wire;
    phase();
    scl <= 1'b0;
  endtask

  // Sends a byte, most significant bit first, and returns the refusal bit.
  task automatic put_byte(input logic [7:0] b, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cell(b[i], s);
    bit_cell(1'b1, nak);
  endtask

  // Receives a byte; the final byte of a read is refused to end it.
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cell(1'b1, s);
      b[i] = s;
    end
    bit_cell(last, s);
  endtask
endmodule

// file: tb/serial_fram_i2c_slave_tb_top.sv
// Purpose: Self-checking bench for the serial byte-memory slave.
// Assumes: The master model paces the bus from the bench clock.
// Notes:   Straps and write-protect start low, as their pull-downs leave them.
module serial_fram_i2c_slave_tb_top
  import fram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk         = 1'b0; // 250 MHz bench clock.
  logic       rst_n       = 1'b0; // Reset, held for four cycles.
  logic [2:0] straps      = 3'h0; // Select straps, pulled low when open.
  logic       wp          = 1'b0; // Write protect, pulled low when open.
  logic       slow        = 1'b0; // Legacy slow bus when high.
  logic       m_scl;              // Master clock drive.
  logic       m_sda;              // Master data drive.
  logic       sda_out;            // Slave drive value.
  logic       sda_oe;             // Slave pull enable.
  int         fails       = 0;    // Mismatches seen.
  int         comparisons = 0;    // Comparisons made.
  wire logic  sda_wire    = m_sda & ~(sda_oe & ~sda_out); // Pull-up unless someone pulls low.

  always #2 clk = ~clk;

  serial_fram_i2c_slave DUT (
    .clk                  (clk),
    .rst_n                (rst_n),
    .scl_in               (m_scl),
    .sda_in               (sda_wire),
    .sda_out              (sda_out),
    .sda_oe               (sda_oe),
    .device_select_straps (straps),
    .write_protect        (wp)
  );

  bus_master_model u_master (
    .clk      (clk),
    .slow     (slow),
    .sda_wire (sda_wire),
    .scl      (m_scl),
    .sda_drv  (m_sda)
  );

  // Compares and reports one value.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic end_sim();
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Sends a byte and checks the acknowledge bit.
  task automatic send(input logic [7:0] b, input logic exp_nak);
    logic nak;
    u_master.put_byte(b, nak);
    check({7'h0, nak}, {7'h0, exp_nak});
  endtask

  // Loads the address latch; the upper three bits of the high address byte are junk.
  task automatic set_addr(input logic [12:0] a, input logic [2:0] sel);
    u_master.bus_start();
    send({DEV_TYPE_CODE, sel, 1'b0}, 1'b0);
    send({3'h7, a[12:8]}, 1'b0);
    send(a[7:0], 1'b0);
  endtask

  // Reads from the current address and compares each byte.
  task automatic read_bytes(input logic [7:0] exp[$], input logic [2:0] sel);
    logic [7:0] b;
    u_master.bus_start();
    send({DEV_TYPE_CODE, sel, 1'b1}, 1'b0);
    foreach (exp[i])
    begin
      u_master.get_byte(i == exp.size() - 1, b);
      check(b, exp[i]);
    end
    u_master.bus_stop();
  endtask

  // Every strap value: a foreign select and a foreign type are refused.
  task automatic t_select();
    for (int s = 0; s < 8; s++)
    begin
      @(posedge clk);
      straps <= s[2:0];
      u_master.bus_start();
      send({DEV_TYPE_CODE, s[2:0] ^ 3'h2, 1'b0}, 1'b1);
      u_master.bus_start();
      send({4'h5, s[2:0], 1'b1}, 1'b1);
      u_master.bus_start();
      send({DEV_TYPE_CODE, s[2:0], 1'b0}, 1'b0);
      u_master.bus_stop();
    end
  endtask

  // Writes across the top of the array and reads it back with no polling.
  task automatic t_wrap();
    @(posedge clk);
    straps <= 3'h5;
    set_addr(13'h1ffe, 3'h5);
    send(8'h5a, 1'b0);
    send(8'hc3, 1'b0);
    send(8'h96, 1'b0);
    send(8'h3c, 1'b0);
    set_addr(13'h1ffe, 3'h5);
    read_bytes('{8'h5a, 8'hc3, 8'h96}, 3'h5);
    read_bytes('{8'h3c}, 3'h5);
  endtask

  // Protected writes are acknowledged and advance the address but store nothing.
  task automatic t_protect();
    @(posedge clk);
    slow   <= 1'b1;
    straps <= 3'h0;
    set_addr(13'h0010, 3'h0);
    send(8'h11, 1'b0);
    send(8'h22, 1'b0);
    send(8'h33, 1'b0);
    u_master.bus_stop();
    @(posedge clk);
    wp <= 1'b1;
    set_addr(13'h0010, 3'h0);
    send(8'haa, 1'b0);
    send(8'hbb, 1'b0);
    u_master.bus_stop();
    read_bytes('{8'h33}, 3'h0);
    set_addr(13'h0010, 3'h0);
    read_bytes('{8'h11, 8'h22}, 3'h0);
  endtask

  // Main sequence.
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_select();
    t_wrap();
    t_protect();
    end_sim();
  end

  // Cuts a hang short.
  initial
  begin
    repeat (100000) @(posedge clk);
    fails++;
    end_sim();
  end
endmodule
